// >>> src/gpio_defs.svh
// register offsets, field positions and reset values of the port configuration block
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define GPIO_PORT_COUNT 3
`define GPIO_PIN_COUNT 8
// per port: five config words, stride of 0x20 bytes
`define GPIO_PORT_STRIDE 8'h20
`define GPIO_OFS_DIRECTION 8'h00
`define GPIO_OFS_LEVEL 8'h04
`define GPIO_OFS_OPEN_DRAIN 8'h08
`define GPIO_OFS_PULL_POLARITY 8'h0c
`define GPIO_OFS_PULL_ENABLE 8'h10
`define GPIO_RESET_BYTE 8'h00
`define GPIO_ANALOG_PORT 2
// port number sits just above the stride; the top address bit lies outside the map
`define GPIO_PORT_SEL_MSB 6
`define GPIO_PORT_SEL_LSB 5
`define GPIO_ADDR_TOP_BIT 7

`endif

// >>> src/gpio_pkg.sv
// types shared by the port configuration block
package gpio_pkg;

    typedef struct packed {
        logic [7:0] pin_direction_bit;
        logic [7:0] pin_level_bit;
        logic [7:0] open_drain_select_bit;
        logic [7:0] pull_polarity_select_bit;
        logic [7:0] pull_enable_bit;
    } port_cfg_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } pad_ctrl_t;

    typedef enum logic [2:0] {
        field_direction,
        field_level,
        field_open_drain,
        field_pull_polarity,
        field_pull_enable,
        field_none
    } cfg_field_t;

endpackage

// >>> src/gpio_pin_configuration.sv
// per-pin configuration of two bidirectional ports and one analog port, reached over apb
// Function
// RQ1: there are two bidirectional ports and one analog port of eight pins, each pin set up on its own.
// RQ2: a direction bit of one makes the pin an output and zero makes it an input.
// RQ3: a pin is either an input or an output at any moment, never both.
// RQ4: an output with open drain cleared drives its data level high or low, with an optional matching pull.
// RQ5: direction one, data zero, open drain one, pull select one and pull enable one give open drain with pull-up.
// RQ6: the same with pull select and pull enable both zero gives open drain left to an external pull-up.
// RQ7: an input reads back the pin level and is tristate, weakly pulled up or weakly pulled down by its pull bits.
// RQ8: the pull devices are switched per pin and hold an undriven pin weakly high or low.
// RQ9: a pull sets the level only while nothing else drives the pin, so an outside driver wins.
// RQ10: all five configuration bits are writable storage updated on the clock edge and act from the next cycle.
`include "gpio_defs.svh"

module gpio_pin_configuration (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pads: level sensed on each pin, and drive controls
    input wire logic [7:0] pin_in [`GPIO_PORT_COUNT],
    output gpio_pkg::pad_ctrl_t pad [`GPIO_PORT_COUNT]
);

    // -----------------------------------------
    // address decode
    // -----------------------------------------
    gpio_pkg::port_cfg_t cfg [`GPIO_PORT_COUNT];
    gpio_pkg::cfg_field_t field;
    logic [1:0] port_sel;
    logic addr_ok;
    logic [7:0] ofs;

    always_comb begin
        field = gpio_pkg::field_none;
        port_sel = paddr[`GPIO_PORT_SEL_MSB:`GPIO_PORT_SEL_LSB];
        ofs = paddr & (`GPIO_PORT_STRIDE - 8'h01);
        case (ofs)
            `GPIO_OFS_DIRECTION: field = gpio_pkg::field_direction;
            `GPIO_OFS_LEVEL: field = gpio_pkg::field_level;
            `GPIO_OFS_OPEN_DRAIN: field = gpio_pkg::field_open_drain;
            `GPIO_OFS_PULL_POLARITY: field = gpio_pkg::field_pull_polarity;
            `GPIO_OFS_PULL_ENABLE: field = gpio_pkg::field_pull_enable;
            default: field = gpio_pkg::field_none;
        endcase
        addr_ok = (field != gpio_pkg::field_none) && (port_sel < 2'(`GPIO_PORT_COUNT)) && !paddr[`GPIO_ADDR_TOP_BIT];
    end

    // zero wait states; unmapped addresses answer with an error and no effect
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    wire access_wr = psel && penable && pwrite && addr_ok;

    // -----------------------------------------
    // per-port storage and pad logic
    // -----------------------------------------
    // RQ1 independent pins
    genvar p;
    generate
        for (p = 0; p < `GPIO_PORT_COUNT; p++) begin : g_port
            wire hit = access_wr && (port_sel == 2'(p));
            // RQ10 clocked config storage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg[p] <= {5{`GPIO_RESET_BYTE}};
                end else if (hit) begin
                    case (field)
                        gpio_pkg::field_direction: cfg[p].pin_direction_bit <= pwdata[7:0];
                        gpio_pkg::field_level: cfg[p].pin_level_bit <= pwdata[7:0];
                        gpio_pkg::field_open_drain: cfg[p].open_drain_select_bit <= pwdata[7:0];
                        gpio_pkg::field_pull_polarity: cfg[p].pull_polarity_select_bit <= pwdata[7:0];
                        gpio_pkg::field_pull_enable: cfg[p].pull_enable_bit <= pwdata[7:0];
                        default: cfg[p] <= cfg[p];
                    endcase
                end
            end
            always_comb begin
                // RQ2 RQ3 direction gates driver
                // RQ4 RQ5 RQ6 push-pull or open drain: open drain drives only low
                pad[p].out = cfg[p].pin_level_bit;
                pad[p].oe_n = ~(cfg[p].pin_direction_bit &
                                (~cfg[p].open_drain_select_bit | ~cfg[p].pin_level_bit));
                // RQ7 RQ8 RQ9 weak pulls, overridden by any driver on the board
                pad[p].pull_up = cfg[p].pull_enable_bit & cfg[p].pull_polarity_select_bit;
                pad[p].pull_down = cfg[p].pull_enable_bit & ~cfg[p].pull_polarity_select_bit;
            end
        end
    endgenerate

    // -----------------------------------------
    // read path
    // -----------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && addr_ok) begin
            case (field)
                gpio_pkg::field_direction: prdata[7:0] = cfg[port_sel].pin_direction_bit;
                // RQ7 inputs read the sensed level, outputs their stored data
                gpio_pkg::field_level: prdata[7:0] = (cfg[port_sel].pin_direction_bit & cfg[port_sel].pin_level_bit)
                                                   | (~cfg[port_sel].pin_direction_bit & pin_in[port_sel]);
                gpio_pkg::field_open_drain: prdata[7:0] = cfg[port_sel].open_drain_select_bit;
                gpio_pkg::field_pull_polarity: prdata[7:0] = cfg[port_sel].pull_polarity_select_bit;
                gpio_pkg::field_pull_enable: prdata[7:0] = cfg[port_sel].pull_enable_bit;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // -----------------------------------------
    // assertions
    // -----------------------------------------
    a_input_no_drive: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        (cfg[0].pin_direction_bit == 8'h00) |-> (pad[0].oe_n == 8'hff))
        else $error("input pin is driven");
    a_write_takes_next: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        (access_wr && field == gpio_pkg::field_direction && port_sel == 2'h1)
        |=> (cfg[1].pin_direction_bit == $past(pwdata[7:0])))
        else $error("direction write not stored");
    a_pushpull_drive: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        (cfg[0].pin_direction_bit[0] && !cfg[0].open_drain_select_bit[0])
        |-> (!pad[0].oe_n[0] && pad[0].out[0] == cfg[0].pin_level_bit[0]))
        else $error("push-pull output not driven");
    a_od_high_release: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        (cfg[0].open_drain_select_bit[0] && cfg[0].pin_level_bit[0]) |-> pad[0].oe_n[0])
        else $error("open drain drives high");
    a_od_low_drive: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        (cfg[1].pin_direction_bit[4] && cfg[1].open_drain_select_bit[4] && !cfg[1].pin_level_bit[4])
        |-> (!pad[1].oe_n[4] && !pad[1].out[4]))
        else $error("open drain not pulling low");
    a_pull_exclusive: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (pad[2].pull_up & pad[2].pull_down) == 8'h00)
        else $error("both pulls on");
    a_pull_up_sel: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (cfg[2].pull_enable_bit[2] && cfg[2].pull_polarity_select_bit[2]) |-> pad[2].pull_up[2])
        else $error("pull-up missing");
    a_read_sensed: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (psel && !pwrite && addr_ok && field == gpio_pkg::field_level && port_sel == 2'h0
         && cfg[0].pin_direction_bit == 8'h00) |-> (prdata[7:0] == pin_in[0]))
        else $error("input read not pin level");

    // -----------------------------------------
    // assertions: pulls and direction
    // -----------------------------------------
    a_pull_down_sel: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (cfg[2].pull_enable_bit[5] && !cfg[2].pull_polarity_select_bit[5])
        |-> (pad[2].pull_down[5] && !pad[2].pull_up[5]))
        else $error("pull-down missing");

    a_pull_off_float: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        !cfg[2].pull_enable_bit[0] |-> (!pad[2].pull_up[0] && !pad[2].pull_down[0]))
        else $error("pull on while disabled");

    a_od_internal_pull: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        (cfg[0].pin_direction_bit[4] && !cfg[0].pin_level_bit[4] && cfg[0].open_drain_select_bit[4]
         && cfg[0].pull_polarity_select_bit[4] && cfg[0].pull_enable_bit[4])
        |-> (!pad[0].oe_n[4] && !pad[0].out[4] && pad[0].pull_up[4]))
        else $error("open drain pull-up state wrong");

    // a driven pin must be an output: catches a driver left on after a direction change
    a_drive_needs_dir: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        (pad[2].oe_n | cfg[2].pin_direction_bit) == 8'hff)
        else $error("driver on an input pin");

    a_od_ext_float: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        (cfg[1].pin_direction_bit[4] && cfg[1].open_drain_select_bit[4] && !cfg[1].pin_level_bit[4]
         && !cfg[1].pull_polarity_select_bit[4] && !cfg[1].pull_enable_bit[4])
        |-> (!pad[1].oe_n[4] && !pad[1].pull_up[4] && !pad[1].pull_down[4]))
        else $error("external pull-up state wrong");

    // the new direction reaches the pad one cycle after the write, not in the write cycle
    a_dir_to_pad: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        (access_wr && field == gpio_pkg::field_direction && port_sel == 2'h2 && pwdata[7:0] == 8'h00)
        |=> (pad[2].oe_n == 8'hff))
        else $error("input direction still driving");

    // -----------------------------------------
    // assertions: bus and storage
    // -----------------------------------------
    a_level_write_next: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        (access_wr && field == gpio_pkg::field_level && port_sel == 2'h2)
        |=> (cfg[2].pin_level_bit == $past(pwdata[7:0])))
        else $error("level write not stored");

    // a refused write must leave every port untouched, aliases included
    a_error_no_store: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        (psel && penable && pwrite && !addr_ok)
        |=> ($stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[2])))
        else $error("refused write changed storage");

    a_error_read_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        (psel && penable && !pwrite && !addr_ok) |-> (prdata == 32'h0000_0000))
        else $error("refused read returned data");

    a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        (psel && !pwrite) |-> (prdata[31:8] == 24'h00_0000))
        else $error("read data above pin field");

    a_read_output_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        (psel && !pwrite && addr_ok && field == gpio_pkg::field_level && port_sel == 2'h1
         && cfg[1].pin_direction_bit == 8'hff) |-> (prdata[7:0] == cfg[1].pin_level_bit))
        else $error("output read not stored data");

    a_read_analog_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (psel && !pwrite && addr_ok && field == gpio_pkg::field_level && port_sel == 2'h2
         && cfg[2].pin_direction_bit == 8'h00) |-> (prdata[7:0] == pin_in[2]))
        else $error("analog input read not pin level");

    // -----------------------------------------
    // cover points
    // -----------------------------------------
    c_od_pullup: cover property (@(posedge pclk) cfg[0].open_drain_select_bit[0] && pad[0].pull_up[0]);
    c_bad_addr: cover property (@(posedge pclk) pslverr);
    c_input_read: cover property (@(posedge pclk) psel && penable && !pwrite && field == gpio_pkg::field_level);
    c_od_external: cover property (@(posedge pclk) cfg[1].open_drain_select_bit[4] && !pad[1].oe_n[4]
        && !pad[1].pull_up[4]);
    c_input_pulldown: cover property (@(posedge pclk) pad[2].pull_down[5] && pad[2].oe_n[5]);

endmodule // gpio_pin_configuration

// >>> testbench/board_model.sv
// board circuitry on the port pins: outside drivers, weak pulls and floating nodes
module board_model (
    // clock
    input wire logic pclk,
    // pad side of the block and outside drivers
    input gpio_pkg::pad_ctrl_t pad [3],
    input wire logic [7:0] ext_en [3],
    input wire logic [7:0] ext_val [3],
    output logic [7:0] pin_in [3]
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last [3] = '{default: 8'h00};
    // pulls hold only an undriven pin
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (!pad[p].oe_n[b]) pin_in[p][b] = pad[p].out[b];
                else if (ext_en[p][b]) pin_in[p][b] = ext_val[p][b];
                else if (pad[p].pull_up[b]) pin_in[p][b] = 1'b1;
                else if (pad[p].pull_down[b]) pin_in[p][b] = 1'b0;
                // floating node wanders so a stale level cannot pass
                else pin_in[p][b] = ~last[p][b];
            end
        end
    end
    always_ff @(posedge pclk) last <= pin_in;
endmodule // board_model

// >>> testbench/test_gpio_pin_configuration.sv
// self-checking bench of the pin configuration block
`include "gpio_defs.svh"
module test_gpio_pin_configuration;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] pin_in [3], ext_en [3] = '{default: 8'h00}, ext_val [3] = '{default: 8'h00};
    gpio_pkg::pad_ctrl_t pad [3];
    int num_errors = 0, checks_done = 0;
    gpio_pin_configuration gpio_pin_configuration_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pad(pad));
    board_model board_model_inst (.pclk(pclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    initial forever #50 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, a[4:0] > 5'h10 || a[1:0] != 2'b00 || a > 8'h5f});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cfg(input int p, input logic [7:0] d, l, o, s, e);
        apb(1, 8'(p * 32) + `GPIO_OFS_DIRECTION, {24'h0, d});
        apb(1, 8'(p * 32) + `GPIO_OFS_LEVEL, {24'h0, l});
        apb(1, 8'(p * 32) + `GPIO_OFS_OPEN_DRAIN, {24'h0, o});
        apb(1, 8'(p * 32) + `GPIO_OFS_PULL_POLARITY, {24'h0, s});
        apb(1, 8'(p * 32) + `GPIO_OFS_PULL_ENABLE, {24'h0, e});
    endtask
    task automatic pad_is(input int p, input logic [31:0] exp);
        chk(pad[p], exp);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    task automatic rd_is(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // idle after reset: tristate inputs, storage cleared
    task automatic test_reset_state;
        for (int p = 0; p < 3; p++) begin
            pad_is(p, 32'h00ff0000);
            rd_is(8'(p * 32) + `GPIO_OFS_DIRECTION, 32'h0);
            rd_is(8'(p * 32) + `GPIO_OFS_PULL_ENABLE, 32'h0);
        end
    endtask
    task automatic test_push_pull;
        for (int p = 0; p < 3; p++) begin
            cfg(p, 8'hff, 8'h5a ^ 8'(p), 8'h00, 8'h00, 8'h00);
            pad_is(p, {8'h5a ^ 8'(p), 24'h0});
            rd_is(8'(p * 32) + `GPIO_OFS_LEVEL, {24'h0, 8'h5a ^ 8'(p)});
            rd_is(8'(p * 32) + `GPIO_OFS_DIRECTION, 32'h0000_00ff);
        end
        // driven high with the matching pull-up on
        cfg(0, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff);
        pad_is(0, 32'hff00ff00);
    endtask
    // low half released high, high half driven low
    task automatic test_od_internal;
        cfg(0, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff);
        pad_is(0, 32'h0f0fff00);
        rd_is(`GPIO_OFS_LEVEL, 32'h0000_000f);
        rd_is(`GPIO_OFS_OPEN_DRAIN, 32'h0000_00ff);
        rd_is(`GPIO_OFS_PULL_POLARITY, 32'h0000_00ff);
    endtask
    task automatic test_od_external;
        cfg(1, 8'hf0, 8'h00, 8'hf0, 8'h00, 8'h00);
        pad_is(1, 32'h000f0000);
        rd_is(8'h20 + `GPIO_OFS_DIRECTION, 32'h0000_00f0);
    endtask
    // outside drivers win over the pulls, pulls hold the rest
    task automatic test_input_pulls;
        cfg(2, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h3c);
        pad_is(2, 32'h00ff0c30);
        ext_en[2] <= 8'h18;
        ext_val[2] <= 8'h10;
        @(posedge pclk);
        apb(1'b0, 8'h40 + `GPIO_OFS_LEVEL, 32'h0);
        chk({28'h0, rd[5:2]}, 32'h0000_0005);
        ext_en[2] <= 8'h00;
        @(posedge pclk);
        apb(1'b0, 8'h40 + `GPIO_OFS_LEVEL, 32'h0);
        chk({28'h0, rd[5:2]}, 32'h0000_0003);
    endtask
    // refused addresses store nothing and read zero
    task automatic test_unmapped;
        apb(1'b1, 8'h14, 32'h0000_00ff);
        apb(1'b1, 8'h84, 32'h0000_0000);
        rd_is(8'h60, 32'h0);
        rd_is(8'h05, 32'h0);
        rd_is(`GPIO_OFS_LEVEL, 32'h0000_000f);
        rd_is(`GPIO_OFS_PULL_ENABLE, 32'h0000_00ff);
    endtask
    task automatic test_mid_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int p = 0; p < 3; p++) begin
            pad_is(p, 32'h00ff0000);
            rd_is(8'(p * 32) + `GPIO_OFS_OPEN_DRAIN, 32'h0);
        end
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset_state();
        test_push_pull();
        test_od_internal();
        test_od_external();
        test_input_pulls();
        test_unmapped();
        test_mid_reset();
        print_verdict();
    end
endmodule // test_gpio_pin_configuration
